// >>> core/smbus_gpio_pkg.sv
// Shared constants for the two-wire slave and its general pin logic.
// Assumes a single 25 MHz clock domain and open-drain pads outside.
package smbus_gpio_pkg;

   // ****************************************
   // Addressing
   // ****************************************
   localparam logic [1:0] SLAVE_ADDR_TOP  = 2'h2;
   localparam logic [6:0] MASS_WRITE_ADDR = 7'h5f;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
   localparam logic [1:0] PIN_LOW         = 2'h0;
   localparam logic [1:0] PIN_OPEN        = 2'h1;
   localparam logic [1:0] PIN_HIGH        = 2'h2;

   // ****************************************
   // Register indices, fields, reset values
   // ****************************************
   localparam logic [2:0] IDX_CTRL        = 3'h0;
   localparam logic [2:0] IDX_ALERT       = 3'h1;
   localparam logic [2:0] IDX_STATUS      = 3'h2;
   localparam logic [2:0] IDX_FAULT       = 3'h3;
   localparam int         POS_MASS_EN     = 4;
   localparam int         POS_MODE_A      = 6;
   localparam int         POS_MODE_B      = 7;
   localparam int         POS_PIN1_OUT    = 6;
   localparam int         POS_PIN1_IN     = 6;
   localparam int         POS_PIN2_IN     = 5;
   localparam int         POS_PIN2_OUT    = 6;
   localparam int         POS_PIN3_OUT    = 7;
   localparam logic [7:0] CTRL_RESET      = 8'hd0;
   localparam logic [7:0] ALERT_RESET     = 8'h40;
   localparam logic [7:0] FAULT_RESET     = 8'h80;
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
   localparam logic [8:0] FILTER_RESET    = 9'h003;
   localparam logic       PIN3_OE_RESET   = 1'b1;

   // ****************************************
   // General pin one modes, from {mode_b, mode_a}
   // ****************************************
   localparam logic [1:0] MODE_PG_HIZ     = 2'h0;
   localparam logic [1:0] MODE_PG_LOW     = 2'h1;
   localparam logic [1:0] MODE_INPUT      = 2'h2;
   localparam logic [1:0] MODE_OUTPUT     = 2'h3;

endpackage

// >>> core/input_filter.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous pins; output updates when stages 2 and 3 agree.
`timescale 1ns/1ps
module input_filter #(
   parameter int               WIDTH       = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input  wire logic             clock, // System clock
   input  wire logic             rst_n, // Synchronous reset, active low
   input  wire logic [WIDTH-1:0] raw,   // Asynchronous pin levels
   output logic      [WIDTH-1:0] clean  // Filtered levels
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, clean_q, clean_d;

   always_comb begin
      // Keep old value while the last two stages disagree
      clean_d = (s2_q & s3_q) | (clean_q & (s2_q ^ s3_q));
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s1_q    <= RESET_VALUE;
         s2_q    <= RESET_VALUE;
         s3_q    <= RESET_VALUE;
         clean_q <= RESET_VALUE;
      end else begin
         s1_q    <= raw;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         clean_q <= clean_d;
      end
   end

   assign clean = clean_q;
endmodule

// >>> core/gpio_drive.sv
// Output enables of the three open-drain general pins.
// Assumes filtered power-good level and alert request on the same clock.
`timescale 1ns/1ps
module gpio_drive (
   input  wire logic       clock,        // System clock
   input  wire logic       rst_n,        // Synchronous reset, active low
   input  wire logic [1:0] pin_one_mode, // Mode of pin one
   input  wire logic       pin1_value,   // Pin one output field
   input  wire logic       pin2_value,   // Pin two output field
   input  wire logic       pin3_value,   // Pin three output field
   input  wire logic       power_good,   // Filtered feedback above threshold
   input  wire logic       alert_active, // Alert wants pin two low
   output logic            pin1_oe,      // Pin one pulls low
   output logic            pin2_oe,      // Pin two pulls low
   output logic            pin3_oe       // Pin three pulls low
);
   logic p1_q, p1_d, p2_q, p2_d, p3_q, p3_d;

   always_comb begin
      unique case (pin_one_mode)
         smbus_gpio_pkg::MODE_PG_HIZ: p1_d = !power_good;
         smbus_gpio_pkg::MODE_PG_LOW: p1_d = power_good;
         smbus_gpio_pkg::MODE_INPUT:  p1_d = 1'b0;
         smbus_gpio_pkg::MODE_OUTPUT: p1_d = !pin1_value;
      endcase
      p2_d = pin2_value || alert_active;
      p3_d = pin3_value;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         p1_q <= 1'b0;
         p2_q <= 1'b0;
         p3_q <= smbus_gpio_pkg::PIN3_OE_RESET;
      end else begin
         p1_q <= p1_d;
         p2_q <= p2_d;
         p3_q <= p3_d;
      end
   end

   assign pin1_oe = p1_q;
   assign pin2_oe = p2_q;
   assign pin3_oe = p3_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   pin1_output_a: assert property (
      pin_one_mode == smbus_gpio_pkg::MODE_OUTPUT |=> pin1_oe == !$past(pin1_value))
      else $error("pin one output mode drive wrong");
   pin1_pgood_a: assert property (
      pin_one_mode == smbus_gpio_pkg::MODE_PG_HIZ |=> pin1_oe != $past(power_good))
      else $error("pin one power-good drive wrong");
   pin1_input_a: assert property (
      pin_one_mode == smbus_gpio_pkg::MODE_INPUT |=> !pin1_oe)
      else $error("pin one driven in input mode");
   pin2_drive_a: assert property (
      ##1 pin2_oe == ($past(pin2_value) || $past(alert_active)))
      else $error("pin two drive wrong");
   pin3_drive_a: assert property (
      pin3_value [*2] |-> pin3_oe)
      else $error("pin three not driven low");
endmodule

// >>> core/smbus_slave_gpio_config.sv
// Two-wire bus slave with byte/word access and general pin configuration.
// Assumes open-drain SCL/SDA pads outside; SCL well below the clock rate.
`timescale 1ns/1ps
// Overview of operation
// - Pin one mode chosen by the two mode-select fields together.
// - After reset pin one is an output, value field resets to released.
// - Pin one may release or pull low on power good, or act as input.
// - Filtered pin one level readable in a status field.
// - Pin two serves as alert output, general output or input.
// - Pin two defaults released, output field resets to 0.
// - Filtered pin two level readable in its own status field.
// - Pin three output field resets to 1, pin driven low.
// - Read-write slave with read/write byte and word commands.
// - Second byte of a word read repeats the first.
// - Second byte of a word write is acknowledged and discarded.
// - SDA falling while SCL high is a start condition.
// - SDA rising while SCL high is a stop, bus free after.
// - Low three bits of the command byte load the register pointer.
// - Slave address top bits fixed at 10, rest from two address pins.
// - Pin two output field set pulls low; cleared releases unless alerting.
module smbus_slave_gpio_config (
   input  wire logic       clock,                     // 25 MHz system clock
   input  wire logic       rst_n,                     // Synchronous reset, active low
   input  wire logic       scl_in,                    // Bus clock level
   input  wire logic       sda_in,                    // Bus data level
   output logic            sda_out,                   // Bus data drive value
   output logic            sda_oe,                    // Bus data pulls low
   input  wire logic       power_good_feedback_input, // Feedback above threshold
   input  wire logic [1:0] slave_id_pin_low,          // Three-level address pin
   input  wire logic [1:0] slave_id_pin_high,         // Three-level address pin
   input  wire logic       alert_active,              // Alert logic wants pin two low
   output logic            alert_release,             // Alert served, one-cycle pulse
   input  wire logic       general_pin_one_in,        // Pin one level
   output logic            general_pin_one_out,       // Pin one drive value
   output logic            general_pin_one_oe,        // Pin one pulls low
   input  wire logic       general_pin_two_in,        // Pin two level
   output logic            general_pin_two_out,       // Pin two drive value
   output logic            general_pin_two_oe,        // Pin two pulls low
   output logic            general_pin_three_out,     // Pin three drive value
   output logic            general_pin_three_oe       // Pin three pulls low
);
   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK,
      S_WDATA, S_WDATA_ACK, S_RDATA, S_MACK, S_IGNORE
   } state_e;

   // ****************************************
   // Input filtering
   // ****************************************
   logic [8:0] clean;
   logic       scl_f, sda_f, pgood_f, pin1_lvl, pin2_lvl;
   logic [1:0] id_lo, id_hi;

   input_filter #(
      .WIDTH       (9),
      .RESET_VALUE (smbus_gpio_pkg::FILTER_RESET)
   ) u_filter (
      .clock (clock),
      .rst_n (rst_n),
      .raw   ({general_pin_two_in, general_pin_one_in, power_good_feedback_input,
               slave_id_pin_high, slave_id_pin_low, sda_in, scl_in}),
      .clean (clean)
   );

   assign scl_f    = clean[0];
   assign sda_f    = clean[1];
   assign id_lo    = clean[3:2];
   assign id_hi    = clean[5:4];
   assign pgood_f  = clean[6];
   assign pin1_lvl = clean[7];
   assign pin2_lvl = clean[8];

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [6:0] decode_id(input logic [1:0] hi, input logic [1:0] lo);
      logic [4:0] low5;
      low5 = 5'h0a;
      case ({hi, lo})
         {smbus_gpio_pkg::PIN_OPEN, smbus_gpio_pkg::PIN_LOW}:  low5 = 5'h08;
         {smbus_gpio_pkg::PIN_HIGH, smbus_gpio_pkg::PIN_OPEN}: low5 = 5'h09;
         {smbus_gpio_pkg::PIN_OPEN, smbus_gpio_pkg::PIN_OPEN}: low5 = 5'h0a;
         {smbus_gpio_pkg::PIN_OPEN, smbus_gpio_pkg::PIN_HIGH}: low5 = 5'h0b;
         {smbus_gpio_pkg::PIN_LOW,  smbus_gpio_pkg::PIN_LOW}:  low5 = 5'h0c;
         {smbus_gpio_pkg::PIN_HIGH, smbus_gpio_pkg::PIN_HIGH}: low5 = 5'h0d;
         {smbus_gpio_pkg::PIN_LOW,  smbus_gpio_pkg::PIN_OPEN}: low5 = 5'h0e;
         {smbus_gpio_pkg::PIN_LOW,  smbus_gpio_pkg::PIN_HIGH}: low5 = 5'h0f;
         {smbus_gpio_pkg::PIN_HIGH, smbus_gpio_pkg::PIN_LOW}:  low5 = 5'h19;
         // Illegal pin code falls back to both-open address
         default:                                              low5 = 5'h0a;
      endcase
      return {smbus_gpio_pkg::SLAVE_ADDR_TOP, low5};
   endfunction

   function automatic logic [7:0] read_value(input logic [2:0] ptr, input logic [7:0] ctrl,
                                             input logic [7:0] alrt, input logic [7:0] flt,
                                             input logic p1, input logic p2);
      logic [7:0] v;
      v = 8'h00;
      unique case (ptr)
         smbus_gpio_pkg::IDX_CTRL:  v = ctrl;
         smbus_gpio_pkg::IDX_ALERT: v = alrt;
         smbus_gpio_pkg::IDX_FAULT: v = flt;
         smbus_gpio_pkg::IDX_STATUS: begin
            v[smbus_gpio_pkg::POS_PIN1_IN] = p1;
            v[smbus_gpio_pkg::POS_PIN2_IN] = p2;
         end
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // ****************************************
   // Bus state machine and registers
   // ****************************************
   state_e     state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d, tx_q, tx_d;
   logic [7:0] ctrl_q, ctrl_d, alrt_q, alrt_d, flt_q, flt_d;
   logic [2:0] ptr_q, ptr_d;
   logic [6:0] own_q, own_d;
   logic       scl_p_q, scl_p_d, sda_p_q, sda_p_d;
   logic       oe_q, oe_d, ara_q, ara_d, word2_q, word2_d, rel_q, rel_d;
   logic       scl_rise, scl_fall, start_ev, stop_ev, rx_state, byte_done;
   logic       own_hit, mass_hit, ara_hit;
   logic [7:0] rd_now;

   assign scl_rise  = scl_f && !scl_p_q;
   assign scl_fall  = !scl_f && scl_p_q;
   assign start_ev  = scl_f && scl_p_q && sda_p_q && !sda_f;
   assign stop_ev   = scl_f && scl_p_q && !sda_p_q && sda_f;
   assign rx_state  = state_q inside {S_ADDR, S_CMD, S_WDATA};
   assign byte_done = scl_fall && cnt_q == smbus_gpio_pkg::BITS_PER_BYTE;
   assign own_hit   = shift_q[7:1] == own_q;
   assign mass_hit  = shift_q[7:1] == smbus_gpio_pkg::MASS_WRITE_ADDR && !shift_q[0]
                      && ctrl_q[smbus_gpio_pkg::POS_MASS_EN];
   // No alert answer while the output field itself holds pin two low
   assign ara_hit   = shift_q[7:1] == smbus_gpio_pkg::ALERT_RESP_ADDR && shift_q[0]
                      && alert_active && !flt_q[smbus_gpio_pkg::POS_PIN2_OUT];
   assign rd_now    = read_value(ptr_q, ctrl_q, alrt_q, flt_q, pin1_lvl, pin2_lvl);

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      tx_d    = tx_q;
      ctrl_d  = ctrl_q;
      alrt_d  = alrt_q;
      flt_d   = flt_q;
      ptr_d   = ptr_q;
      oe_d    = oe_q;
      ara_d   = ara_q;
      word2_d = word2_q;
      rel_d   = 1'b0;
      own_d   = decode_id(id_hi, id_lo);
      scl_p_d = scl_f;
      sda_p_d = sda_f;
      if (scl_rise && (rx_state || state_q == S_RDATA)) begin
         cnt_d = cnt_q + 4'h1;
      end
      if (scl_rise && rx_state) begin
         shift_d = {shift_q[6:0], sda_f};
      end
      if (stop_ev) begin
         state_d = S_IDLE;
         oe_d    = 1'b0;
      end else if (start_ev) begin
         state_d = S_ADDR;
         cnt_d   = 4'h0;
         oe_d    = 1'b0;
      end else begin
         unique case (state_q)
            S_IDLE, S_IGNORE: ;
            S_ADDR: if (byte_done) begin
               if (own_hit || mass_hit || ara_hit) begin
                  state_d = S_ADDR_ACK;
                  oe_d    = 1'b1;
                  ara_d   = ara_hit;
                  rel_d   = own_hit && alert_active;
               end else begin
                  state_d = S_IGNORE;
               end
            end
            S_ADDR_ACK: if (scl_fall) begin
               cnt_d   = 4'h0;
               word2_d = 1'b0;
               if (shift_q[0]) begin
                  state_d = S_RDATA;
                  tx_d    = ara_q ? {own_q, 1'b0} : rd_now;
                  oe_d    = ara_q ? !own_q[6] : !rd_now[7];
                  rel_d   = ara_q;
               end else begin
                  state_d = S_CMD;
                  oe_d    = 1'b0;
               end
            end
            S_CMD: if (byte_done) begin
               state_d = S_CMD_ACK;
               oe_d    = 1'b1;
               ptr_d   = shift_q[2:0];
            end
            S_CMD_ACK: if (scl_fall) begin
               state_d = S_WDATA;
               cnt_d   = 4'h0;
               oe_d    = 1'b0;
            end
            S_WDATA: if (byte_done) begin
               state_d = S_WDATA_ACK;
               oe_d    = 1'b1;
               word2_d = 1'b1;
               // Second byte of a word write is acknowledged only
               if (!word2_q) begin
                  unique case (ptr_q)
                     smbus_gpio_pkg::IDX_CTRL:  ctrl_d = shift_q;
                     smbus_gpio_pkg::IDX_ALERT: alrt_d = shift_q;
                     smbus_gpio_pkg::IDX_FAULT: flt_d  = shift_q;
                     default: ;
                  endcase
               end
            end
            S_WDATA_ACK: if (scl_fall) begin
               state_d = S_WDATA;
               cnt_d   = 4'h0;
               oe_d    = 1'b0;
            end
            S_RDATA: if (byte_done) begin
               state_d = S_MACK;
               oe_d    = 1'b0;
            end else if (scl_fall) begin
               oe_d = !tx_q[3'd7 - cnt_q[2:0]];
            end
            S_MACK: if (scl_rise && sda_f) begin
               state_d = S_IGNORE;
            end else if (scl_fall) begin
               state_d = S_RDATA;
               cnt_d   = 4'h0;
               tx_d    = ara_q ? {own_q, 1'b0} : rd_now;
               oe_d    = ara_q ? !own_q[6] : !rd_now[7];
            end
            default: state_d = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         tx_q    <= 8'h00;
         ctrl_q  <= smbus_gpio_pkg::CTRL_RESET;
         alrt_q  <= smbus_gpio_pkg::ALERT_RESET;
         flt_q   <= smbus_gpio_pkg::FAULT_RESET;
         ptr_q   <= 3'h0;
         own_q   <= 7'h4a;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         oe_q    <= 1'b0;
         ara_q   <= 1'b0;
         word2_q <= 1'b0;
         rel_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         tx_q    <= tx_d;
         ctrl_q  <= ctrl_d;
         alrt_q  <= alrt_d;
         flt_q   <= flt_d;
         ptr_q   <= ptr_d;
         own_q   <= own_d;
         scl_p_q <= scl_p_d;
         sda_p_q <= sda_p_d;
         oe_q    <= oe_d;
         ara_q   <= ara_d;
         word2_q <= word2_d;
         rel_q   <= rel_d;
      end
   end

   assign sda_out       = 1'b0;
   assign sda_oe        = oe_q;
   assign alert_release = rel_q;

   // ****************************************
   // General pins
   // ****************************************
   gpio_drive u_gpio (
      .clock        (clock),
      .rst_n        (rst_n),
      .pin_one_mode ({ctrl_q[smbus_gpio_pkg::POS_MODE_B],
                      ctrl_q[smbus_gpio_pkg::POS_MODE_A]}),
      .pin1_value   (alrt_q[smbus_gpio_pkg::POS_PIN1_OUT]),
      .pin2_value   (flt_q[smbus_gpio_pkg::POS_PIN2_OUT]),
      .pin3_value   (flt_q[smbus_gpio_pkg::POS_PIN3_OUT]),
      .power_good   (pgood_f),
      .alert_active (alert_active),
      .pin1_oe      (general_pin_one_oe),
      .pin2_oe      (general_pin_two_oe),
      .pin3_oe      (general_pin_three_oe)
   );

   assign general_pin_one_out   = 1'b0;
   assign general_pin_two_out   = 1'b0;
   assign general_pin_three_out = 1'b0;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   start_seen_a: assert property (start_ev && !stop_ev |=> state_q == S_ADDR)
      else $error("start not recognised");
   stop_free_a: assert property (stop_ev |=> state_q == S_IDLE && !sda_oe)
      else $error("stop did not free bus");
   ptr_load_a: assert property (state_q == S_CMD_ACK |-> ptr_q == shift_q[2:0])
      else $error("pointer not loaded from command");
   ignore_quiet_a: assert property (state_q == S_IGNORE |-> !sda_oe)
      else $error("SDA driven while ignoring");
   addr_top_a: assert property (own_q[6:5] == smbus_gpio_pkg::SLAVE_ADDR_TOP)
      else $error("address top bits wrong");
   word_discard_a: assert property (
      state_q == S_WDATA && word2_q |=> $stable(ctrl_q) && $stable(alrt_q) && $stable(flt_q))
      else $error("second write byte changed a register");
   byte_write_a: assert property (
      state_q == S_WDATA && byte_done && !word2_q && !stop_ev && !start_ev
      && ptr_q == smbus_gpio_pkg::IDX_CTRL |=> ctrl_q == $past(shift_q))
      else $error("write byte not stored");
   read_repeat_a: assert property (
      state_q == S_RDATA && !ara_q && ptr_q != smbus_gpio_pkg::IDX_STATUS |-> tx_q == rd_now)
      else $error("read byte differs from register");
   status_level_a: assert property (
      state_q == S_ADDR_ACK && scl_fall && shift_q[0] && ptr_q == smbus_gpio_pkg::IDX_STATUS
      && !ara_q |=> tx_q[6] == $past(pin1_lvl) && tx_q[5] == $past(pin2_lvl))
      else $error("status does not show pin levels");

   write_done_c: cover property (state_q == S_WDATA && word2_q ##1 state_q == S_WDATA_ACK);
   read_word_c:  cover property (state_q == S_MACK && scl_fall ##1 state_q == S_RDATA);
   alert_resp_c: cover property (ara_q && state_q == S_RDATA);
   stop_c:       cover property (stop_ev && state_q == S_MACK);
endmodule

// >>> bench/smbus_master_model.sv
// Bus master model: frames, bytes and acknowledges on SCL/SDA.
// Assumes a pull-up on SDA; SCL stands high between frames.
`timescale 1ns/1ps
module smbus_master_model (
   input  wire logic clock,    // System clock
   input  wire logic sda_line, // Resolved SDA level
   output logic      scl,      // Bus clock
   output logic      sda_rel   // High releases SDA
);
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic gap(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Phases of 10 clocks stay above the slave's filter minimum
   task automatic clk_bit(input logic b, output logic r);
      sda_rel <= b;
      gap(5);
      scl <= 1'b1;
      gap(10);
      r = sda_line;
      scl <= 1'b0;
      gap(5);
   endtask
   task automatic start();
      sda_rel <= 1'b1;
      gap(5);
      scl <= 1'b1;
      gap(10);
      sda_rel <= 1'b0;
      gap(10);
      scl <= 1'b0;
      gap(5);
   endtask
   task automatic stop();
      sda_rel <= 1'b0;
      gap(5);
      scl <= 1'b1;
      gap(10);
      sda_rel <= 1'b1;
      gap(10);
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], r);
      end
      clk_bit(1'b1, r);
      ack = ~r;
   endtask
   task automatic rd_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, r);
         d[i] = r;
      end
      clk_bit(nack, r);
   endtask
endmodule

// >>> bench/smbus_slave_gpio_config_test.sv
// Self-checking bench for the two-wire slave and its general pins.
// Assumes address pins give 7'h4b; the master model drives the bus.
`timescale 1ns/1ps
module smbus_slave_gpio_config_test;
   logic        clock, rst_n, pgood, alert_active, p1_drv, p2_drv;
   logic        sda_oe, p1_oe, p2_oe, p3_oe, scl, sda_rel, ack, rel;
   logic [7:0]  got, d0, d1, r, e;
   logic [7:0]  exp_q[$];
   logic [31:0] lfsr_q;
   int          fail_count, samples_checked, rel_n;
   event        got_ev;
   wire logic   sda_line = sda_rel & ~sda_oe;
   smbus_master_model m (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
   smbus_slave_gpio_config DUT (.clock(clock), .rst_n(rst_n), .scl_in(scl),
      .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .power_good_feedback_input(pgood),
      .slave_id_pin_low(smbus_gpio_pkg::PIN_HIGH), .slave_id_pin_high(smbus_gpio_pkg::PIN_OPEN),
      .alert_active(alert_active), .alert_release(rel),
      .general_pin_one_in(p1_drv & ~p1_oe), .general_pin_one_out(), .general_pin_one_oe(p1_oe),
      .general_pin_two_in(p2_drv & ~p2_oe), .general_pin_two_out(), .general_pin_two_oe(p2_oe),
      .general_pin_three_out(), .general_pin_three_oe(p3_oe));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Alert release is a one-cycle pulse, so count every one seen
   always @(posedge clock) begin
      if (rel === 1'b1) begin
         rel_n++;
      end
   end
   task automatic close_out();
      $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic note(input logic [7:0] x, input logic [7:0] g);
      exp_q.push_back(x);
      got = g;
      ->got_ev;
      @(posedge clock);
   endtask
   initial forever begin
      @got_ev;
      samples_checked++;
      if (got !== exp_q[0]) begin
         fail_count++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, exp_q[0], got);
      end
      void'(exp_q.pop_front());
   end
   // Word write sends the inverse as second byte, so keeping it would show
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic word);
      m.start();
      m.wr_byte(8'h96, ack);
      m.wr_byte(idx, ack);
      m.wr_byte(d, ack);
      if (word) begin
         m.wr_byte(~d, ack);
      end
      m.stop();
      note(8'h01, {7'h00, ack});
   endtask
   task automatic rd(input logic [7:0] idx);
      m.start();
      m.wr_byte(8'h96, ack);
      m.wr_byte(idx, ack);
      m.start();
      m.wr_byte(8'h97, ack);
      m.rd_byte(1'b0, d0);
      m.rd_byte(1'b1, d1);
      m.stop();
   endtask
   task automatic pins(input logic [2:0] x);
      repeat (20) @(posedge clock);
      note({5'h00, x}, {5'h00, p1_oe, p2_oe, p3_oe});
   endtask
   initial begin
      repeat (100000) @(posedge clock);
      fail_count++;
      close_out();
   end
   initial begin
      {rst_n, pgood, alert_active} = 3'h0;
      {p1_drv, p2_drv} = 2'h3;
      lfsr_q = 32'h5f401d67;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      pins(3'h1);
      rd(8'h00);
      note(8'hd0, d0);
      wr(8'h03, 8'h40, 1'b1);
      pins(3'h2);
      rd(8'hf3);
      note(8'h40, d0);
      note(8'h40, d1);
      wr(8'h03, 8'h00, 1'b0);
      alert_active <= 1'b1;
      pins(3'h2);
      m.start();
      m.wr_byte(8'h19, ack);
      m.rd_byte(1'b1, d0);
      m.stop();
      note(8'h96, d0);
      note(8'h01, rel_n[7:0]);
      alert_active <= 1'b0;
      m.start();
      m.wr_byte(8'hbe, ack);
      m.wr_byte(8'h01, ack);
      m.wr_byte(8'h00, ack);
      m.stop();
      pins(3'h4);
      for (int k = 0; k < 4; k++) begin
         lfsr_q = lfsr_next(lfsr_q);
         r = lfsr_q[7:0];
         wr(8'h01, r, 1'b0);
         rd(8'h01);
         note(r, d0);
         note(r, d1);
         pins({~r[6], 2'h0});
      end
      wr(8'h01, 8'h00, 1'b0);
      for (int md = 0; md < 8; md++) begin
         wr(8'h00, {md[2:1], 6'h10}, 1'b0);
         pgood <= md[0];
         e[0] = (md[2:1] == 0) ? ~md[0] : (md[2:1] == 1) ? md[0] : md[1];
         pins({e[0], 2'h0});
      end
      wr(8'h00, 8'h90, 1'b0);
      for (int k = 0; k < 4; k++) begin
         p1_drv <= k[0];
         p2_drv <= k[1];
         rd(8'h02);
         note({1'b0, k[0], k[1], 5'h00}, d0 & 8'h60);
      end
      m.start();
      m.wr_byte(8'h98, ack);
      m.stop();
      note(8'h00, {7'h00, ack});
      close_out();
   end
endmodule
